// [hw/css_pkg.sv]
// package of register map, field positions, modes and state record for the sync serial block
package css_pkg;
  // word-aligned byte offsets on the register bus
  localparam int CSS_AW = 5;
  localparam logic [4:0] CSS_OFF_CTRL = 5'h00;
  localparam logic [4:0] CSS_OFF_STAT = 5'h04;
  localparam logic [4:0] CSS_OFF_BRG = 5'h08;
  localparam logic [4:0] CSS_OFF_TXB = 5'h0C;
  localparam logic [4:0] CSS_OFF_RXB = 5'h10;
  // control register fields
  localparam int CSS_CTRL_W = 15;
  localparam int C_TXEN = 0;
  localparam int C_RXEN = 1;
  localparam int C_CLKEXT = 2;
  localparam int C_SRC = 3;
  localparam int C_FLOW = 5;
  localparam int C_POL = 7;
  localparam int C_MSB = 8;
  localparam int C_CONT = 9;
  localparam int C_PINSEL = 10;
  localparam int C_DINV = 11;
  localparam int C_LINV = 12;
  localparam int C_TISEL = 13;
  localparam int C_ODRAIN = 14;
  // status register fields
  localparam int S_BUSY = 0;
  localparam int S_TBE = 1;
  localparam int S_TXE = 2;
  localparam int S_TXIR = 3;
  localparam int S_RXIR = 4;
  localparam int S_OVR = 5;
  localparam int S_RXFULL = 6;
  // byte lane split and frame geometry
  localparam int CSS_B0_HI = 7;
  localparam int CSS_B1_LO = 8;
  localparam int CSS_MSB = 7;
  localparam logic [2:0] CSS_LAST_BIT = 3'h7;
  localparam logic [3:0] CSS_FRAME_BITS = 4'h8;
  // prescaler terminal counts for the divide-by-8 and divide-by-32 sources
  localparam logic [2:0] CSS_PRE8 = 3'h7;
  localparam logic [4:0] CSS_PRE32 = 5'h1F;

  typedef enum logic [1:0] {CSS_SRC_DIV1, CSS_SRC_DIV8, CSS_SRC_DIV32} css_src_e;
  typedef enum logic [1:0] {CSS_FLOW_NONE, CSS_FLOW_CTS, CSS_FLOW_RTS} css_flow_e;
  typedef enum logic {CSS_IDLE, CSS_SHIFT} css_state_e;

  typedef struct packed {
    logic [CSS_CTRL_W-1:0] ctrl;
    logic [7:0] brg;
    logic [7:0] txbuf;
    logic [7:0] sh;
    logic [7:0] rxsh;
    logic [7:0] rxbuf;
    logic tbe, txe, tx_ir, rx_ir, rx_full, ovr, arm, rx_on, seen;
    css_state_e st;
    logic [2:0] cnt;
    logic [4:0] pre;
    logic [7:0] div;
    logic sclk, tx_bit;
    logic clk_s1, clk_s2, clk_s3, rxd_s1, rxd_s2, cts_s1, cts_s2;
    logic txd, txd_oe_n, clk_oe_a_n, clk_oe_b_n, rts_n;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] hb;
    logic [8:0] ht;
  } css_st_s;

  localparam css_st_s CSS_ST_RST = '{tbe: 1'b1, txe: 1'b1, sclk: 1'b1, tx_bit: 1'b1,
    clk_s1: 1'b1, clk_s2: 1'b1, clk_s3: 1'b1, rxd_s1: 1'b1, rxd_s2: 1'b1, cts_s1: 1'b1,
    cts_s2: 1'b1, txd: 1'b1, clk_oe_a_n: 1'b1, clk_oe_b_n: 1'b1, rts_n: 1'b1,
    st: CSS_IDLE, default: '0};
endpackage : css_pkg

// [hw/css_top.sv]
// clock synchronous serial channel with a classic wishbone register slave
//
// Operation
// - frames are exactly eight bits, no framing
// - internal clock is source over 2(n+1)
// - clock-select one takes clock from pin
// - divider n is the 8-bit rate setting
// - flow control: cts, rts or none
// - transmit starts on enable, data, cts low
// - receive needs receive, transmit enable, data
// - transmit request on buffer to shifter move
// - transmit request on shifter done, if selected
// - receive request on frame into buffer
// - overrun when unread frame is replaced
// - overrun frame overwrites receive buffer
// - overrun leaves receive request untouched
// - polarity picks shift and sample edges
// - bit order lsb or msb first
// - continuous mode: buffer read rearms reception
// - clock output routed to one of two pins
// - optional data inversion on buffer access
// - optional line level inversion of pins
// - output pin idles high before first transfer
`timescale 1ns/1ps
module css_top
  import css_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [CSS_AW-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_clk_pin,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  output logic o_clk_out,
  output logic o_clk_oe_a_n,
  output logic o_clk_oe_b_n,
  output logic o_txd,
  output logic o_txd_oe_n,
  output logic o_rts_n,
  output logic o_tx_irq,
  output logic o_rx_irq
);

  css_st_s st_q;
  css_st_s st_d;
  logic req;
  logic src_tick;
  logic edge_hit;
  logic new_lvl;
  logic lead;
  logic trail;
  logic start;
  logic done;
  logic cts_ok;
  logic ext_ok;
  logic rx_bit;
  logic [7:0] inv_mask;

  // all next-state logic in one pass; later sections see the bus effects,
  // so a hardware event in the same cycle as a software clear wins
  always_comb begin
    st_d = st_q;
    req = i_wb_cyc && i_wb_stb && !st_q.ack;
    src_tick = 1'b0;
    edge_hit = 1'b0;
    new_lvl = st_q.sclk;
    lead = 1'b0;
    trail = 1'b0;
    start = 1'b0;
    done = 1'b0;
    inv_mask = {8{st_q.ctrl[C_DINV]}};

    // two-flop synchronisers; logic reads the second stage, and the clock edge detect also reads the third
    st_d.clk_s1 = i_clk_pin;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    st_d.rxd_s1 = i_rxd;
    st_d.rxd_s2 = st_q.rxd_s1;
    st_d.cts_s1 = i_cts_n;
    st_d.cts_s2 = st_q.cts_s1;
    rx_bit = st_q.rxd_s2 ^ st_q.ctrl[C_LINV];

    // register slave: answers one cycle after the request, unmapped reads zero
    st_d.ack = req;
    if (req) begin
      st_d.rdat = '0;
      case (i_wb_adr)
        CSS_OFF_CTRL: begin
          st_d.rdat[CSS_CTRL_W-1:0] = st_q.ctrl;
          if (i_wb_we && i_wb_sel[0]) begin
            st_d.ctrl[CSS_B0_HI:0] = i_wb_dat[CSS_B0_HI:0];
          end
          if (i_wb_we && i_wb_sel[1]) begin
            st_d.ctrl[CSS_CTRL_W-1:CSS_B1_LO] = i_wb_dat[CSS_CTRL_W-1:CSS_B1_LO];
          end
        end
        CSS_OFF_STAT: begin
          st_d.rdat[S_BUSY] = (st_q.st == CSS_SHIFT);
          st_d.rdat[S_TBE] = st_q.tbe;
          st_d.rdat[S_TXE] = st_q.txe;
          st_d.rdat[S_TXIR] = st_q.tx_ir;
          st_d.rdat[S_RXIR] = st_q.rx_ir;
          st_d.rdat[S_OVR] = st_q.ovr;
          st_d.rdat[S_RXFULL] = st_q.rx_full;
          // request and overrun flags clear by writing one
          if (i_wb_we && i_wb_sel[0]) begin
            if (i_wb_dat[S_TXIR]) st_d.tx_ir = 1'b0;
            if (i_wb_dat[S_RXIR]) st_d.rx_ir = 1'b0;
            if (i_wb_dat[S_OVR]) st_d.ovr = 1'b0;
          end
        end
        CSS_OFF_BRG: begin
          st_d.rdat[CSS_B0_HI:0] = st_q.brg;
          if (i_wb_we && i_wb_sel[0]) st_d.brg = i_wb_dat[CSS_B0_HI:0];
        end
        CSS_OFF_TXB: begin
          st_d.rdat[CSS_B0_HI:0] = st_q.txbuf ^ inv_mask;
          if (i_wb_we && i_wb_sel[0]) begin
            st_d.txbuf = i_wb_dat[CSS_B0_HI:0] ^ inv_mask;
            st_d.tbe = 1'b0;
          end
        end
        CSS_OFF_RXB: begin
          st_d.rdat[CSS_B0_HI:0] = st_q.rxbuf ^ inv_mask;
          if (!i_wb_we) begin
            st_d.rx_full = 1'b0;
            // a read alone rearms reception in continuous mode
            if (st_q.ctrl[C_CONT] && st_q.ctrl[C_RXEN]) st_d.arm = 1'b1;
          end
        end
        default: st_d.rdat = '0;
      endcase
    end

    // free-running prescaler gives the three divider source rates
    st_d.pre = st_q.pre + 5'h01;
    case (st_q.ctrl[C_SRC +: 2])
      CSS_SRC_DIV8: src_tick = (st_q.pre[2:0] == CSS_PRE8);
      CSS_SRC_DIV32: src_tick = (st_q.pre == CSS_PRE32);
      default: src_tick = 1'b1;
    endcase

    // start qualifiers; an external master must hold the idle level first
    cts_ok = (st_q.ctrl[C_FLOW +: 2] != CSS_FLOW_CTS) || !st_q.cts_s2;
    ext_ok = !st_q.ctrl[C_CLKEXT] || (st_q.clk_s2 != st_q.ctrl[C_POL]);

    case (st_q.st)
      CSS_IDLE: begin
        st_d.div = '0;
        if (!st_q.ctrl[C_CLKEXT]) st_d.sclk = !st_q.ctrl[C_POL];
        if (st_q.ctrl[C_TXEN] && cts_ok && ext_ok &&
            (!st_d.tbe || (st_d.arm && st_q.ctrl[C_RXEN]))) begin
          start = 1'b1;
          st_d.st = CSS_SHIFT;
          st_d.cnt = '0;
          st_d.hb = '0;
          st_d.ht = '0;
          st_d.arm = 1'b0;
          st_d.seen = 1'b1;
          st_d.txe = 1'b0;
          st_d.rx_on = st_q.ctrl[C_RXEN];
          // fresh data moves to the shifter; a continuous rearm sends the shifter's fill of ones
          if (!st_d.tbe) begin
            st_d.sh = st_d.txbuf;
            st_d.tbe = 1'b1;
            if (!st_q.ctrl[C_TISEL]) st_d.tx_ir = 1'b1;
          end
          st_d.tx_bit = st_q.ctrl[C_MSB] ? st_d.sh[CSS_MSB] : st_d.sh[0];
        end
      end
      CSS_SHIFT: begin
        if (st_q.ctrl[C_CLKEXT]) begin
          edge_hit = (st_q.clk_s2 != st_q.clk_s3);
          new_lvl = st_q.clk_s2;
        end else if (src_tick) begin
          st_d.ht = st_q.ht + 9'h001;
          // toggle every n+1 source ticks: a full period is 2(n+1) ticks
          if (st_q.div == st_q.brg) begin
            edge_hit = 1'b1;
            new_lvl = !st_q.sclk;
            st_d.sclk = new_lvl;
            st_d.div = '0;
            st_d.ht = '0;
          end else begin
            st_d.div = st_q.div + 8'h01;
          end
        end
        // leaving idle level shifts out, returning to it samples in
        lead = edge_hit && (new_lvl == st_q.ctrl[C_POL]);
        trail = edge_hit && (new_lvl != st_q.ctrl[C_POL]);
        if (lead) st_d.tx_bit = st_q.ctrl[C_MSB] ? st_q.sh[CSS_MSB] : st_q.sh[0];
        if (trail) begin
          st_d.hb = st_q.hb + 4'h1;
          st_d.cnt = st_q.cnt + 3'h1;
          if (st_q.ctrl[C_MSB]) begin
            st_d.sh = {st_q.sh[CSS_MSB-1:0], 1'b1};
            st_d.rxsh = {st_q.rxsh[CSS_MSB-1:0], rx_bit};
          end else begin
            st_d.sh = {1'b1, st_q.sh[CSS_MSB:1]};
            st_d.rxsh = {rx_bit, st_q.rxsh[CSS_MSB:1]};
          end
          if (st_q.cnt == CSS_LAST_BIT) begin
            done = 1'b1;
            st_d.st = CSS_IDLE;
            st_d.txe = 1'b1;
            if (st_q.ctrl[C_TISEL]) st_d.tx_ir = 1'b1;
            if (st_q.rx_on) begin
              st_d.rxbuf = st_d.rxsh;
              // an unread frame is lost: flag it but raise no new request
              if (st_d.rx_full) begin
                st_d.ovr = 1'b1;
              end else begin
                st_d.rx_full = 1'b1;
                st_d.rx_ir = 1'b1;
              end
            end
          end
        end
      end
      default: st_d.st = CSS_IDLE;
    endcase

    // pin registers; until the first frame the output stays high
    st_d.txd = st_d.seen ? (st_d.tx_bit ^ st_q.ctrl[C_LINV]) : 1'b1;
    st_d.txd_oe_n = st_q.ctrl[C_ODRAIN] && st_d.txd;
    // clock pins drive only with the internal clock, on the chosen pin
    st_d.clk_oe_a_n = st_q.ctrl[C_CLKEXT] || st_q.ctrl[C_PINSEL];
    st_d.clk_oe_b_n = st_q.ctrl[C_CLKEXT] || !st_q.ctrl[C_PINSEL];
    // in rts flow mode, ready-to-receive while reception is enabled and the buffer is free
    st_d.rts_n = !((st_q.ctrl[C_FLOW +: 2] == CSS_FLOW_RTS) && st_q.ctrl[C_RXEN] &&
      !st_d.rx_full);
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      st_q <= CSS_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // every output straight from the state record
  assign o_wb_dat = st_q.rdat;
  assign o_wb_ack = st_q.ack;
  assign o_clk_out = st_q.sclk;
  assign o_clk_oe_a_n = st_q.clk_oe_a_n;
  assign o_clk_oe_b_n = st_q.clk_oe_b_n;
  assign o_txd = st_q.txd;
  assign o_txd_oe_n = st_q.txd_oe_n;
  assign o_rts_n = st_q.rts_n;
  assign o_tx_irq = st_q.tx_ir;
  assign o_rx_irq = st_q.rx_ir;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  logic stat_wr;
  assign stat_wr = req && i_wb_we && (i_wb_adr == CSS_OFF_STAT);
  // bus strobes for the buffer checks below
  logic txb_wr;
  logic rxb_rd;
  assign txb_wr = req && i_wb_we && i_wb_sel[0] && (i_wb_adr == CSS_OFF_TXB);
  assign rxb_rd = req && !i_wb_we && (i_wb_adr == CSS_OFF_RXB);

  // a frame ends after exactly eight sampled bits
  chk_frame_eight: assert property (done |-> st_q.hb == CSS_FRAME_BITS - 4'h1)
    else $error("frame ended without eight bits");

  // internal toggles are spaced by n+1 source ticks
  chk_int_divider: assert property (
    (st_q.st == CSS_SHIFT && !st_q.ctrl[C_CLKEXT] && src_tick && edge_hit)
      |-> st_q.ht == {1'b0, st_q.brg})
    else $error("internal clock half period wrong");

  // external clock mode never drives the clock pins
  chk_ext_no_drive: assert property (
    st_q.ctrl[C_CLKEXT] [*2] |-> o_clk_oe_a_n && o_clk_oe_b_n)
    else $error("clock pin driven in external mode");

  // a frame starts only when enable and cts allow it
  chk_tx_start: assert property (
    (st_q.st == CSS_IDLE) ##1 (st_q.st == CSS_SHIFT)
      |-> $past(st_q.ctrl[C_TXEN]) && $past(cts_ok))
    else $error("transfer started without its conditions");

  // a start with receive enabled switches reception on
  chk_rx_start: assert property (start && st_q.ctrl[C_RXEN] |=> st_q.rx_on)
    else $error("receive not armed at start");

  // loading the shifter empties the buffer and may request an interrupt
  chk_load_flags: assert property (
    start && !st_q.tbe && !st_q.ctrl[C_TISEL] && !(req && i_wb_we)
      |=> st_q.tbe && st_q.tx_ir)
    else $error("buffer load flags missing");

  // end of shifting requests a transmit interrupt when so selected
  chk_tx_end_irq: assert property (done && st_q.ctrl[C_TISEL] |=> o_tx_irq && st_q.txe)
    else $error("no transmit request at frame end");

  // a first frame raises the receive request
  chk_rx_irq: assert property (
    done && st_q.rx_on && !st_q.rx_full && !stat_wr |=> o_rx_irq && st_q.rx_full)
    else $error("no receive request on new frame");

  // an overrun overwrites the buffer and keeps the request as it was
  chk_overrun: assert property (
    done && st_q.rx_on && st_q.rx_full && !req
      |=> st_q.ovr && st_q.rxbuf == $past(st_d.rxsh) && st_q.rx_ir == $past(st_q.rx_ir))
    else $error("overrun handling wrong");

  // line stays high until the first frame starts
  chk_idle_high: assert property (!st_q.seen && $past(!st_q.seen) |-> o_txd)
    else $error("output not high before first frame");

  // a buffer write leaves data pending unless a load takes it at once
  chk_tbe_write: assert property (txb_wr && !start |=> !st_q.tbe)
    else $error("buffer write did not clear empty flag");

  // cts high at the pin holds a waiting frame back
  chk_cts_hold: assert property (
    st_q.st == CSS_IDLE && st_q.ctrl[C_FLOW +: 2] == CSS_FLOW_CTS && st_q.cts_s2
      |=> st_q.st == CSS_IDLE)
    else $error("frame started while cts high");

  // without transmit enable neither side of the link may start
  chk_no_tx_en: assert property (
    st_q.st == CSS_IDLE && !st_q.ctrl[C_TXEN] |=> st_q.st == CSS_IDLE)
    else $error("frame started with transmit disabled");

  // a buffer read in continuous mode leaves reception armed or running
  chk_cont_arm: assert property (
    rxb_rd && st_q.ctrl[C_CONT] && st_q.ctrl[C_RXEN] |=> st_q.arm || st_q.st == CSS_SHIFT)
    else $error("continuous read did not rearm");

  // an armed channel starts without fresh transmit data
  chk_cont_start: assert property (
    st_q.arm && st_q.st == CSS_IDLE && st_q.ctrl[C_TXEN] && st_q.ctrl[C_RXEN] && cts_ok &&
      ext_ok |=> st_q.st == CSS_SHIFT)
    else $error("armed reception did not start");

  // an overrun keeps the buffer marked full
  chk_ovr_full: assert property (
    done && st_q.rx_on && st_q.rx_full && !req |=> st_q.rx_full)
    else $error("overrun cleared the full mark");

  // a frame shifted with reception off leaves the buffer alone
  chk_rx_off: assert property (done && !st_q.rx_on |=> $stable(st_q.rxbuf))
    else $error("buffer written with reception off");

  // the internal clock rests at its idle level between frames
  chk_clk_idle: assert property (
    st_q.st == CSS_IDLE && $past(st_q.st) == CSS_IDLE && !st_q.ctrl[C_CLKEXT] &&
      $stable(st_q.ctrl) |-> o_clk_out != st_q.ctrl[C_POL])
    else $error("internal clock not at idle level");

  // open drain floats the pin whenever the line is high
  chk_open_drain: assert property (
    $stable(st_q.ctrl[C_ODRAIN]) |-> o_txd_oe_n == (st_q.ctrl[C_ODRAIN] && o_txd))
    else $error("output enable wrong for drive mode");

  // ready-to-receive follows mode, enable and a free buffer
  chk_rts_level: assert property (
    $stable(st_q.ctrl) |-> o_rts_n == !((st_q.ctrl[C_FLOW +: 2] == CSS_FLOW_RTS) &&
      st_q.ctrl[C_RXEN] && !st_q.rx_full))
    else $error("rts level wrong");

  cov_full_frame: cover property (start ##[1:600] done);
  cov_overrun: cover property (done && st_q.rx_on && st_q.rx_full);
  cov_ext_frame: cover property (done && st_q.ctrl[C_CLKEXT]);
  cov_cont_rearm: cover property (start && st_q.arm && st_q.tbe);
  cov_cts_frame: cover property (start && st_q.ctrl[C_FLOW +: 2] == CSS_FLOW_CTS);
endmodule : css_top

// [test/css_far_model.sv]
// far-side serial device that shares the transfer clock
`timescale 1ns/1ps
module css_far_model (
  input wire logic i_clk_sys,
  input wire logic i_sclk,
  input wire logic i_txd,
  input wire logic i_pol,
  input wire logic i_msb,
  input wire logic i_clr,
  input wire logic [7:0] i_byte,
  output logic o_rxd,
  output logic [7:0] o_cap,
  output logic [3:0] o_cnt,
  output logic [15:0] o_half
);
  logic prev = 1'b1;
  logic [15:0] run = 16'h0000;
  logic [2:0] k;
  initial o_rxd = 1'b1;
  initial o_cnt = 4'h0;
  assign k = i_msb ? 3'h7 - o_cnt[2:0] : o_cnt[2:0];
  // edges are seen one cycle late, well inside each half period
  always @(posedge i_clk_sys) begin
    prev <= i_sclk;
    run <= run + 16'h0001;
    if (i_clr) begin
      o_cnt <= 4'h0;
    end else if (i_sclk != prev && o_cnt < 4'h8) begin
      o_half <= run;
      run <= 16'h0001;
      if (i_sclk == i_pol) begin
        o_rxd <= i_byte[k];
      end else begin
        o_cap[k] <= i_txd;
        o_cnt <= o_cnt + 4'h1;
        // a released line shows the inverse, never the last bit
        if (o_cnt == 4'h7) o_rxd <= ~o_rxd;
      end
    end
  end
endmodule : css_far_model

// [test/css_top_tb.sv]
// self-checking bench for the sync serial channel
`timescale 1ns/1ps
module css_top_tb
  import css_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0, we = 1'b0, cts_n = 1'b0, clk_pin = 1'b1, pclr = 1'b0, ext = 1'b0;
  logic ppol = 1'b0, pmsb = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h00000000, rdat, q;
  logic ack, txd, ca_n, cb_n, sclk, rts_n, tx_irq, rx_irq, rxd, oe_n;
  logic [7:0] pbyte = 8'h00, pcap, d, p;
  logic [3:0] pcnt;
  logic [15:0] phalf;
  logic [14:0] cfg [6];
  int err_total = 0, num_checks = 0, i;
  always #50 clk = ~clk;
  css_top uut (.i_clk_sys(clk), .i_resetn(rst_n), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_clk_pin(clk_pin), .i_rxd(rxd), .i_cts_n(cts_n), .o_clk_out(sclk),
    .o_clk_oe_a_n(ca_n), .o_clk_oe_b_n(cb_n), .o_txd(txd), .o_txd_oe_n(oe_n), .o_rts_n(rts_n),
    .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
  css_far_model far (.i_clk_sys(clk), .i_sclk(ext ? clk_pin : sclk), .i_txd(txd),
    .i_pol(ppol), .i_msb(pmsb), .i_clr(pclr), .i_byte(pbyte), .o_rxd(rxd), .o_cap(pcap),
    .o_cnt(pcnt), .o_half(phalf));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    q = rdat;
    req <= 1'b0;
    if (k == 20) begin
      err_total++;
      results();
    end
  endtask : wb
  // bounded wait: 0 rx request, 1 tx request, 2 far side saw eight bits
  task automatic wt(input int s);
    int k;
    for (k = 0; k < 9000; k++) begin
      @(posedge clk);
      if ((s == 0 && rx_irq === 1'b1) || (s == 1 && tx_irq === 1'b1)) break;
      if (s == 2 && pcnt === 4'h8) break;
    end
    if (k == 9000) begin
      err_total++;
      results();
    end
    // the far side captures the last bit on the edge the request shows up
    repeat (2) @(posedge clk);
  endtask : wt
  task automatic setc(input logic [14:0] c);
    ppol <= c[C_POL];
    pmsb <= c[C_MSB];
    wb(1'b1, CSS_OFF_CTRL, {17'h00000, c});
    wb(1'b1, CSS_OFF_STAT, 32'h00000038);
  endtask : setc
  // far side is cleared while the buffer is written
  task automatic load(input logic [7:0] dv, input logic [7:0] pv);
    pbyte <= pv;
    pclr <= 1'b1;
    wb(1'b1, CSS_OFF_TXB, {24'h000000, dv});
    pclr <= 1'b0;
  endtask : load
  task automatic frame(input logic [14:0] c, input logic [7:0] n);
    logic [7:0] m;
    int t;
    m = {8{c[C_DINV] ^ c[C_LINV]}};
    t = c[C_SRC+1] ? 32 : (c[C_SRC] ? 8 : 1);
    d = 8'($urandom);
    p = 8'($urandom);
    wb(1'b1, CSS_OFF_BRG, {24'h000000, n});
    setc(c);
    load(d, p);
    wt(1);
    repeat (3) @(posedge clk);
    chk(32'(pcnt), c[C_TISEL] ? 32'h8 : 32'h0);
    chk(32'({ca_n, cb_n}), c[C_PINSEL] ? 32'h2 : 32'h1);
    wt(0);
    chk(32'(pcap), 32'(d ^ m));
    chk(32'(phalf), (32'(n) + 1) * t);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    chk(q & 32'hFF, 32'(p ^ m));
  endtask : frame
  initial begin
    cfg = '{15'h0003, 15'h0083, 15'h0503, 15'h2983, 15'h102B, 15'h0013};
    i = $urandom(32'h360E);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({txd, oe_n, tx_irq, rx_irq}), 32'h8);
    wb(1'b0, CSS_OFF_STAT, 32'h00000000);
    chk(q & 32'h7F, 32'h06);
    for (i = 0; i < 6; i++) frame(cfg[i], 8'(3 + $urandom % 5));
    $display("test frames done");
    // second frame lands on an unread buffer
    setc(15'h0003);
    load(8'h5A, 8'hC3);
    wt(0);
    wb(1'b1, CSS_OFF_STAT, 32'h00000038);
    load(8'hA5, 8'h3C);
    wt(2);
    repeat (20) @(posedge clk);
    wb(1'b0, CSS_OFF_STAT, 32'h00000000);
    chk(q & 32'h30, 32'h20);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    chk(q & 32'hFF, 32'h3C);
    $display("test overrun done");
    cts_n <= 1'b1;
    setc(15'h0023);
    load(8'h81, 8'h7E);
    repeat (100) @(posedge clk);
    wb(1'b0, CSS_OFF_STAT, 32'h00000000);
    chk(32'({pcnt, q[S_TBE]}), 32'h0);
    cts_n <= 1'b0;
    wt(0);
    chk(32'(pcap), 32'h81);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    setc(15'h0002);
    load(8'h00, 8'hFF);
    repeat (100) @(posedge clk);
    chk(32'({pcnt, rx_irq}), 32'h0);
    setc(15'h0043);
    wt(0);
    @(posedge clk);
    chk(32'(rts_n), 32'h1);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    chk(q & 32'hFF, 32'hFF);
    repeat (2) @(posedge clk);
    chk(32'(rts_n), 32'h0);
    $display("test flow done");
    // bench acts as clock master, idling high for polarity zero
    ext <= 1'b1;
    setc(15'h0007);
    load(8'h96, 8'h69);
    repeat (16) begin
      repeat (6) @(posedge clk);
      clk_pin <= ~clk_pin;
    end
    repeat (20) @(posedge clk);
    chk(32'({pcap, ca_n, cb_n}), 32'h25B);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    chk(q & 32'hFF, 32'h69);
    $display("test external clock done");
    // continuous receive with open drain: a buffer read alone starts the next frame
    ext <= 1'b0;
    setc(15'h4203);
    load(8'h3C, 8'hA6);
    wt(0);
    chk(32'({pcap, txd, oe_n}), 32'h0F0);
    wb(1'b1, CSS_OFF_STAT, 32'h00000038);
    pbyte <= 8'h5C;
    pclr <= 1'b1;
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    pclr <= 1'b0;
    chk(q & 32'hFF, 32'hA6);
    wt(0);
    chk(32'({pcap, txd, oe_n}), 32'h3FF);
    wb(1'b0, CSS_OFF_RXB, 32'h00000000);
    chk(q & 32'hFF, 32'h5C);
    $display("test continuous done");
    results();
  end
endmodule : css_top_tb
